// ### design/input_capture_channel.sv
// Input capture channel: edge capture of a timer count into a FIFO
`timescale 1ns/1ps
`default_nettype none
module input_capture_channel
  import capture_pkg::*;
#(
  parameter int CHANNEL_INDEX = 0
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RST,
  // Register port
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [15:0]       WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [15:0]       RDATA,
  // Time bases
  input  wire logic [15:0]       SECOND_TIMER_COUNT,
  input  wire logic [15:0]       THIRD_TIMER_COUNT,
  // Power state
  input  wire logic              CPU_IDLE,
  input  wire logic              CPU_SLEEP,
  // Pin
  input  wire logic              CAPTURE_INPUT_PIN,
  // Events out
  output logic                   IRQ,
  output logic                   WAKE
);
  initial begin
    if (CHANNEL_INDEX < 0 || CHANNEL_INDEX > 7) $error("At most 8");
  end
  // ==========================================================
  // Control register
  logic [15:0]      ctrl_q;
  logic             ovf_q;
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] mask_q;
  logic [1:0]       cap_cnt_q;
  logic             wake_q;
  logic             irq_q;
  logic [15:0]      rdata_q;

  wire [2:0] mode          = ctrl_q[POS_MODE +: 3];
  wire [1:0] cpi           = ctrl_q[POS_CPI +: 2];
  wire       tb_sel        = ctrl_q[BIT_TB_SEL];
  wire       stop_in_idle  = ctrl_q[BIT_STOP_IDLE];
  wire       low_power     = CPU_IDLE || CPU_SLEEP;
  // Sleep stops the instruction clock; capture halts while wake logic and the registers keep running
  wire       halted        = CPU_SLEEP || (CPU_IDLE && stop_in_idle);
  wire       run           = !halted;

  // ==========================================================
  // Register decode
  wire wr_ctrl = WR && (ADDR == ADDR_CTRL);
  wire wr_stat = WR && (ADDR == ADDR_INT_STAT);
  wire wr_mask = WR && (ADDR == ADDR_INT_MASK);
  wire rd_buf  = RD && (ADDR == ADDR_BUF);

  // ==========================================================
  // Edge qualification
  logic capture_evt;
  logic rise_evt;
  capture_edge_qual u_qual (
    .clk         (CLK),
    .rst         (RST),
    .mode        (mode),
    .run         (run),
    .pin         (CAPTURE_INPUT_PIN),
    .capture_evt (capture_evt),
    .rise_evt    (rise_evt)
  );

  // ==========================================================
  // Capture FIFO
  logic [15:0] head;
  logic        not_empty;
  logic        full;
  wire  [15:0] tb_value = tb_sel ? SECOND_TIMER_COUNT
                                 : THIRD_TIMER_COUNT;
  wire         overflow_evt = capture_evt && full;
  capture_fifo u_fifo (
    .clk       (CLK),
    .rst       (RST),
    .push      (capture_evt),
    .push_data (tb_value),
    .pop       (rd_buf),
    .head      (head),
    .not_empty (not_empty),
    .full      (full)
  );

  // ==========================================================
  // Interrupt counting
  wire stored       = capture_evt && !full;
  wire cnt_done     = (cap_cnt_q == cpi);
  wire cap_irq      = stored &&
                      ((mode == MODE_EVERY_EDGE) || cnt_done);
  // Wake-only mode fires on a rising edge only in low power
  wire wake_evt     = (mode == MODE_WAKE_ONLY) && low_power &&
                      rise_evt;
  wire pin_wake     = low_power && (wake_evt || capture_evt);
  wire [IRQ_W-1:0] evt_vec = {wake_evt, overflow_evt, cap_irq};
  wire [IRQ_W-1:0] clr_vec = wr_stat ? WDATA[IRQ_W-1:0] : '0;

  always_ff @(posedge CLK) begin
    if (RST) begin
      cap_cnt_q <= 2'h0;
    end else if (wr_ctrl || mode == MODE_EVERY_EDGE) begin
      // Rewriting control restarts the capture count
      cap_cnt_q <= 2'h0;
    end else if (stored) begin
      cap_cnt_q <= cnt_done ? 2'h0 : cap_cnt_q + 2'h1;
    end
  end

  // ==========================================================
  // Control, status and mask registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_q <= CTRL_RESET;
      mask_q <= IRQ_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= WDATA & CTRL_WR_MASK;
      end
      if (wr_mask) begin
        mask_q <= WDATA[IRQ_W-1:0];
      end
    end
  end

  // Overflow clears when the FIFO is empty or the mode is off
  always_ff @(posedge CLK) begin
    if (RST) begin
      ovf_q <= 1'b0;
    end else if (overflow_evt) begin
      ovf_q <= 1'b1;
    end else if (!not_empty || (mode == MODE_OFF)) begin
      ovf_q <= 1'b0;
    end
  end

  // Set wins over write-one-to-clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      stat_q <= IRQ_RESET;
    end else begin
      stat_q <= (stat_q & ~clr_vec) | evt_vec;
    end
  end

  // ==========================================================
  // Outputs and read data
  wire [15:0] ctrl_view = ctrl_q
                          | (16'(ovf_q)     << BIT_OVF)
                          | (16'(not_empty) << BIT_BNE);
  logic [15:0] rd_mux;
  always_comb begin
    unique case (ADDR)
      ADDR_CTRL:     rd_mux = ctrl_view;
      ADDR_BUF:      rd_mux = not_empty ? head : 16'h0000;
      ADDR_INT_STAT: rd_mux = 16'(stat_q);
      ADDR_INT_MASK: rd_mux = 16'(mask_q);
      default:       rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_q <= 16'h0000;
      irq_q   <= 1'b0;
      wake_q  <= 1'b0;
    end else begin
      rdata_q <= RD ? rd_mux : 16'h0000;
      irq_q   <= |(((stat_q & ~clr_vec) | evt_vec) & mask_q);
      wake_q  <= pin_wake;
    end
  end

  assign RDATA = rdata_q;
  assign IRQ   = irq_q;
  assign WAKE  = wake_q;
endmodule : input_capture_channel
`default_nettype wire

// ### design/capture_pkg.sv
// Package of constants shared by the input capture design
package capture_pkg;
  // ==========================================================
  // Register map (word addresses on the plain port)
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  ADDR_CTRL       = 4'h0;
  localparam logic [3:0]  ADDR_BUF        = 4'h1;
  localparam logic [3:0]  ADDR_INT_STAT   = 4'h2;
  localparam logic [3:0]  ADDR_INT_MASK   = 4'h3;
  // ==========================================================
  // Control register fields
  localparam int          BIT_STOP_IDLE   = 13;
  localparam int          BIT_TB_SEL      = 7;
  localparam int          POS_CPI         = 5;
  localparam int          BIT_OVF         = 4;
  localparam int          BIT_BNE         = 3;
  localparam int          POS_MODE        = 0;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic [15:0] CTRL_WR_MASK    = 16'h20E7;
  // ==========================================================
  // Interrupt status bits
  localparam int          IRQ_W           = 3;
  localparam int          IRQ_CAPTURE     = 0;
  localparam int          IRQ_OVERFLOW    = 1;
  localparam int          IRQ_WAKE        = 2;
  localparam logic [2:0]  IRQ_RESET       = 3'h0;
  // ==========================================================
  // Capture modes
  localparam logic [2:0]  MODE_OFF        = 3'h0;
  localparam logic [2:0]  MODE_EVERY_EDGE = 3'h1;
  localparam logic [2:0]  MODE_FALL       = 3'h2;
  localparam logic [2:0]  MODE_RISE       = 3'h3;
  localparam logic [2:0]  MODE_RISE_4     = 3'h4;
  localparam logic [2:0]  MODE_RISE_16    = 3'h5;
  localparam logic [2:0]  MODE_UNUSED     = 3'h6;
  localparam logic [2:0]  MODE_WAKE_ONLY  = 3'h7;
  localparam logic [3:0]  PRESCALE_4_LAST  = 4'h3;
  localparam logic [3:0]  PRESCALE_16_LAST = 4'hF;
  localparam int          FIFO_DEPTH      = 4;
  localparam int          DATA_W          = 16;
endpackage : capture_pkg

// ### design/capture_fifo.sv
// Capture value FIFO with drop-on-full and a full flag
`timescale 1ns/1ps
`default_nettype none
module capture_fifo
  import capture_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Write side
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  // Read side
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head,
  output logic                  not_empty,
  output logic                  full
);
  localparam int PW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH) $error("DEPTH power of two >= 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wp_q;
  logic [PW-1:0]    rp_q;
  logic [PW:0]      cnt_q;
  wire              do_pop  = pop && (cnt_q != '0);
  wire              do_push = push && !full;
  assign full      = (cnt_q == (PW+1)'(DEPTH));
  assign not_empty = (cnt_q != '0);
  assign head      = mem[rp_q];
  // ==========================================================
  // Storage
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wp_q] <= push_data;
    end
  end
  // ==========================================================
  // Pointers
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (do_pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end
endmodule : capture_fifo
`default_nettype wire

// ### design/capture_edge_qual.sv
// Edge detection and prescaling of the capture input
`timescale 1ns/1ps
`default_nettype none
module capture_edge_qual
  import capture_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic [2:0] mode,
  input  wire logic       run,
  input  wire logic       pin,
  // Result
  output logic            capture_evt,
  output logic            rise_evt
);
  logic       pin_q;
  logic [3:0] pre_q;
  logic [2:0] mode_q;
  wire rise = pin && !pin_q;
  wire fall = !pin && pin_q;
  wire pre4  = (mode == MODE_RISE_4)  && (pre_q == PRESCALE_4_LAST);
  wire pre16 = (mode == MODE_RISE_16) && (pre_q == PRESCALE_16_LAST);
  assign rise_evt = rise;
  always_comb begin
    capture_evt = 1'b0;
    if (run) begin
      unique case (mode)
        MODE_EVERY_EDGE: capture_evt = rise || fall;
        MODE_FALL:       capture_evt = fall;
        MODE_RISE:       capture_evt = rise;
        MODE_RISE_4:     capture_evt = rise && pre4;
        MODE_RISE_16:    capture_evt = rise && pre16;
        default:         capture_evt = 1'b0;
      endcase
    end
  end
  // Prescaler restarts on any mode change so counts are aligned
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_q  <= 1'b0;
      pre_q  <= '0;
      mode_q <= MODE_OFF;
    end else begin
      pin_q  <= pin;
      mode_q <= mode;
      if (mode != mode_q) begin
        pre_q <= '0;
      end else if (run && rise) begin
        pre_q <= (pre4 || pre16) ? 4'h0 : pre_q + 4'h1;
      end
    end
  end
endmodule : capture_edge_qual
`default_nettype wire

// ### verification/input_capture_channel_asserts.sv
// Concurrent checks on the capture channel ports
`timescale 1ns/1ps
`default_nettype none
module input_capture_channel_asserts
  import capture_pkg::*;
(
  // Clock and reset
  input wire logic              CLK,
  input wire logic              RST,
  // Register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic              WR,
  input wire logic              RD,
  input wire logic [15:0]       RDATA,
  // Power, pin and events
  input wire logic              CPU_IDLE,
  input wire logic              CPU_SLEEP,
  input wire logic              CAPTURE_INPUT_PIN,
  input wire logic              IRQ,
  input wire logic              WAKE
);
  // ====================================================
  // Recent causes, three deep to span the IRQ register stage
  logic       pin_q;
  logic [2:0] cause_q;
  logic [2:0] wr_q;
  wire logic  cause_now;
  assign cause_now = (CAPTURE_INPUT_PIN != pin_q) ||
                     (WR && ADDR == ADDR_INT_MASK);
  always_ff @(posedge CLK) begin
    pin_q   <= CAPTURE_INPUT_PIN;
    cause_q <= RST ? 3'h0 : {cause_q[1:0], cause_now};
    wr_q    <= RST ? 3'h0 : {wr_q[1:0], WR};
  end
  // ====================================================
  // Properties
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data not zero outside the read slot");
  a_unmapped_zero: assert property (RD ##1 $past(ADDR) > ADDR_INT_MASK |-> RDATA == 16'h0000)
    else $error("unmapped read not zero");
  a_ctrl_spare: assert property ($past(RD) && $past(ADDR) == ADDR_CTRL |-> (RDATA & ~(CTRL_WR_MASK | 16'h0018)) == 16'h0000)
    else $error("spare control bits read nonzero");
  a_ovf_needs_data: assert property ($past(RD) && $past(ADDR) == ADDR_CTRL && RDATA[BIT_OVF] |-> RDATA[BIT_BNE])
    else $error("overflow shown with empty buffer");
  a_stat_spare: assert property ($past(RD) && $past(ADDR) == ADDR_INT_STAT |-> RDATA[15:IRQ_W] == 13'h0000)
    else $error("spare status bits read nonzero");
  a_irq_rise: assert property ($rose(IRQ) |-> |cause_q)
    else $error("interrupt rose with no pin event or mask write");
  a_irq_fall: assert property ($fell(IRQ) |-> |wr_q)
    else $error("interrupt fell with no register write");
  a_wake_power: assert property (WAKE |-> $past(CPU_SLEEP || CPU_IDLE))
    else $error("wake pulse outside low power");
  a_wake_edge: assert property (WAKE |-> $past(CAPTURE_INPUT_PIN) != $past(CAPTURE_INPUT_PIN, 2))
    else $error("wake pulse without a pin edge");
  c_wake: cover property (WAKE);
  c_irq: cover property ($rose(IRQ));
  c_ovf: cover property ($past(RD) && RDATA[BIT_OVF]);
endmodule : input_capture_channel_asserts
`default_nettype wire

// ### verification/capture_pin_model.sv
// Model of the signal source on the capture input pin
`timescale 1ns/1ps
`default_nettype none
module capture_pin_model (
  // Clock
  input  wire logic clk,
  // Pin
  output var logic  pin
);
  initial pin = 1'b0;
  // High for hi cycles; two spare cycles let the falling edge land
  task automatic pulse(input int hi);
    @(posedge clk) pin <= 1'b1;
    repeat (hi) @(posedge clk);
    pin <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse
endmodule : capture_pin_model
`default_nettype wire

// ### verification/tb_input_capture_channel.sv
// Self-checking bench for the input capture channel
`timescale 1ns/1ps
`default_nettype none
module tb_input_capture_channel;
  import capture_pkg::*;
  logic              clk = 1'b0;
  logic              rst;
  logic [ADDR_W-1:0] addr;
  logic [15:0]       wdata;
  logic              wr;
  logic              rd;
  logic [15:0]       sec;
  logic [15:0]       thr;
  logic              idle;
  logic              sleep;
  logic [15:0]       wake_cnt = 16'h0000;
  logic [15:0]       rdata, v, n, k, c;
  logic              pin, irq, wake;
  int                num_errors = 0;
  int                cmp_count = 0;
  logic [2:0]  mode_tab [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0, 3'h6, 3'h7};
  logic [15:0] exp_tab [8] = '{16'h0020, 16'h0010, 16'h0010, 16'h0004,
                               16'h0001, 16'h0000, 16'h0000, 16'h0000};
  always #2 clk = ~clk;
  always @(posedge clk) if (wake === 1'b1) wake_cnt <= wake_cnt + 16'h0001;
  input_capture_channel input_capture_channel_i (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SECOND_TIMER_COUNT(sec), .THIRD_TIMER_COUNT(thr),
    .CPU_IDLE(idle), .CPU_SLEEP(sleep), .CAPTURE_INPUT_PIN(pin),
    .IRQ(irq), .WAKE(wake));
  capture_pin_model capture_pin_model_i (.clk(clk), .pin(pin));
  // ====================================================
  // Bus and compare tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd_reg(a, d);
    chk(d, exp);
  endtask : rd_chk
  task automatic set_cnt(input logic [15:0] s, input logic [15:0] t);
    @(posedge clk);
    sec <= s;
    thr <= t;
  endtask : set_cnt
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  // ====================================================
  // Watchdog, well past the roughly 1300 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test;
  end
  // ====================================================
  // Tests
  initial begin
    rst   <= 1'b1;
    addr  <= 4'h0;
    wdata <= 16'h0000;
    wr    <= 1'b0;
    rd    <= 1'b0;
    sec   <= 16'h0000;
    thr   <= 16'h0000;
    idle  <= 1'b0;
    sleep <= 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_chk(ADDR_CTRL, 16'h0000);
    rd_chk(4'hF, 16'h0000);
    wr_reg(ADDR_INT_MASK, 16'h0007);
    rd_chk(ADDR_INT_MASK, 16'h0007);
    $display("test reset done");
    wr_reg(ADDR_CTRL, 16'h0083);
    for (k = 16'h0000; k < 16'h0005; k++) begin
      set_cnt(16'h1000 + k, 16'h2000 + k);
      capture_pin_model_i.pulse(1);
    end
    rd_chk(ADDR_CTRL, 16'h009B);
    for (k = 16'h0000; k < 16'h0004; k++) begin
      rd_chk(ADDR_BUF, 16'h1000 + k);
    end
    rd_chk(ADDR_CTRL, 16'h0083);
    wr_reg(ADDR_CTRL, 16'h009B);
    rd_chk(ADDR_CTRL, 16'h0083);
    rd_chk(ADDR_INT_STAT, 16'h0003);
    wr_reg(ADDR_INT_STAT, 16'h0003);
    rd_chk(ADDR_INT_STAT, 16'h0000);
    wr_reg(ADDR_CTRL, 16'h0003);
    set_cnt(16'h1111, 16'h2222);
    capture_pin_model_i.pulse(3);
    rd_chk(ADDR_BUF, 16'h2222);
    $display("test fifo done");
    set_cnt(16'hBEEF, 16'h0001);
    for (int m = 0; m < 8; m++) begin
      wr_reg(ADDR_CTRL, {13'h0010, mode_tab[m]});
      n = 16'h0000;
      repeat (16) begin
        capture_pin_model_i.pulse(1);
        repeat (2) begin
          rd_reg(ADDR_BUF, v);
          n += {15'h0000, v != 16'h0000};
        end
      end
      chk(n, exp_tab[m]);
    end
    $display("test modes done");
    wr_reg(ADDR_INT_MASK, 16'h0001);
    for (c = 16'h0000; c < 16'h0004; c++) begin
      wr_reg(ADDR_CTRL, {9'h000, c[1:0], 5'h03});
      wr_reg(ADDR_INT_STAT, 16'h0007);
      for (k = 16'h0000; k <= c; k++) begin
        capture_pin_model_i.pulse(1);
        chk({15'h0000, irq}, {15'h0000, k == c});
      end
      repeat (4) rd_reg(ADDR_BUF, v);
    end
    wr_reg(ADDR_CTRL, 16'h0061);
    wr_reg(ADDR_INT_STAT, 16'h0007);
    capture_pin_model_i.pulse(1);
    chk({15'h0000, irq}, 16'h0001);
    wr_reg(ADDR_INT_MASK, 16'h0000);
    rd_chk(ADDR_INT_STAT, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    repeat (2) rd_reg(ADDR_BUF, v);
    $display("test interrupts done");
    wr_reg(ADDR_INT_MASK, 16'h0007);
    wr_reg(ADDR_INT_STAT, 16'h0007);
    wr_reg(ADDR_CTRL, 16'h0007);
    sleep <= 1'b1;
    capture_pin_model_i.pulse(3);
    chk(wake_cnt, 16'h0001);
    rd_chk(ADDR_INT_STAT, 16'h0004);
    rd_chk(ADDR_BUF, 16'h0000);
    sleep <= 1'b0;
    idle  <= 1'b1;
    wr_reg(ADDR_CTRL, 16'h2003);
    capture_pin_model_i.pulse(1);
    rd_chk(ADDR_BUF, 16'h0000);
    wr_reg(ADDR_CTRL, 16'h0003);
    set_cnt(16'h1111, 16'h3C3C);
    capture_pin_model_i.pulse(1);
    rd_chk(ADDR_BUF, 16'h3C3C);
    chk(wake_cnt, 16'h0002);
    $display("test low power done");
    stop_test;
  end
endmodule : tb_input_capture_channel
bind input_capture_channel input_capture_channel_asserts
  input_capture_channel_asserts_i (.CLK, .RST, .ADDR, .WR, .RD, .RDATA,
  .CPU_IDLE, .CPU_SLEEP, .CAPTURE_INPUT_PIN, .IRQ, .WAKE);
`default_nettype wire
